// file: logic/stg_pkg.sv
// What this block does
// [R1] Terminal mode passes line B1 B2 D E upstream.
// [R2] Otherwise every filled backplane bit is one.
// [R3] Controller issues activation request for downstream data.
// [R4] Disabled state machine: transmit block bit gates downstream.
// [R5] Fixed D delay only with stop/go off.
// [R6] Class 8 waits for eighth echo bit.
// [R7] Trunk mode: no fixed frame alignment.
// [R8] Subscriber and network modes pass B1 B2 D.
// [R9] Handler may withhold D access; never assumed.
// [R10] Level detector reports signal during analog loop.
// [R11] Phase delay shift advances transmit by 260 ns.
// [R12] Forwarding condition re-evaluated once per frame.
package stg_pkg;

  // ****************************************
  // Clock and link timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int BP_CLK_NS = 125;
  localparam int DCL_HALF_CYC = (BP_CLK_NS * CLK_MHZ / 1000) / 2;
  localparam int TX_BASE_NS = 520;
  localparam int PHASE_SHIFT_NS = 260;
  localparam int TX_BASE_CYC = TX_BASE_NS * CLK_MHZ / 1000;
  localparam int PHASE_SHIFT_CYC = PHASE_SHIFT_NS * CLK_MHZ / 1000;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int FRAME_BITS = 32;
  localparam int FRAME_CYC = FRAME_BITS * 2 * DCL_HALF_CYC;
  localparam int CHAN_BITS = 19;
  localparam logic [4:0] LAST_BIT = 5'h1f;
  localparam logic [4:0] FIRST_BIT = 5'h00;
  localparam logic [12:0] PAD_ONES = 13'h1fff;
  localparam logic [18:0] CHAN_ONES = 19'h7ffff;
  localparam int FIFO_DEPTH = 16;

  // ****************************************
  // Control encodings and reset values
  // ****************************************
  localparam logic [2:0] TX_INFO_PASS = 3'h3;
  localparam logic [3:0] PRIO_CLASS8 = 4'h8;
  localparam logic [3:0] PRIO_CLASS10 = 4'ha;
  localparam logic [7:0] DELAY_RST = 8'h00;
  localparam logic [3:0] ECHO_RST = 4'h0;
  localparam logic [3:0] DIV_RST = 4'h0;

  typedef struct packed {
    logic e;
    logic [1:0] d;
    logic [7:0] b2;
    logic [7:0] b1;
  } stg_chan_t;

  typedef enum logic [1:0] {
    MODE_TERMINAL = 2'h0,
    MODE_LINE_TERMINAL_TRUNK = 2'h1,
    MODE_LINE_TERMINAL_SUBSCRIBER = 2'h3,
    MODE_NETWORK = 2'h2
  } stg_mode_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_DELAY = 2'h1,
    TX_STOPGO = 2'h2
  } stg_tx_state_t;

endpackage : stg_pkg

// file: logic/stg_link_if.sv
`timescale 1ns/100ps
interface stg_link_if;
  logic dcl;
  logic fsc;
  logic dd;
  logic du;
  modport dev (input dcl, input fsc, input dd, output du);
  modport ctl (output dcl, output fsc, output dd, input du);
endinterface : stg_link_if

// file: logic/stg_device.sv
`timescale 1ns/100ps

// ****************************************
// Receive word buffer
// ****************************************
module stg_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  always_comb begin
    in_ready = (cnt_r != (AW+1)'(DEPTH));
    out_valid = (cnt_r != '0);
    out_data = mem_r[rp_r];
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule : stg_fifo

// ****************************************
// Transceiver end of the backplane link
// ****************************************
module stg_device (
  input wire logic ref_clk,
  input wire logic arst_n,
  stg_link_if.dev link,
  input wire stg_pkg::stg_mode_t mode,
  input wire logic activated_state,
  input wire logic sm_disable,
  input wire logic [2:0] transmit_info_select,
  input wire logic transmit_data_block,
  input wire logic activate_request_class8,
  input wire logic activate_request_class10,
  input wire logic activate_request_loop,
  input wire logic [2:0] d_channel_access_mode,
  input wire logic phase_delay_shift,
  input wire logic line_rx_valid,
  output logic line_rx_ready,
  input wire stg_pkg::stg_chan_t line_rx_chan,
  input wire logic line_signal_present,
  output logic level_detect,
  output logic line_tx_valid,
  output stg_pkg::stg_chan_t line_tx_chan
);
  import stg_pkg::*;

  // ****************************************
  // Synchronisers
  // ****************************************
  logic dcl_s1_r, dcl_s2_r, dcl_d_r, fsc_s1_r, fsc_s2_r, dd_s1_r, dd_s2_r;
  logic lvl_s1_r, lvl_s2_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dcl_s1_r <= 1'b1;
      dcl_s2_r <= 1'b1;
      dcl_d_r <= 1'b1;
      fsc_s1_r <= 1'b0;
      fsc_s2_r <= 1'b0;
      dd_s1_r <= 1'b1;
      dd_s2_r <= 1'b1;
      lvl_s1_r <= 1'b0;
      lvl_s2_r <= 1'b0;
    end else begin
      dcl_s1_r <= link.dcl;
      dcl_s2_r <= dcl_s1_r;
      dcl_d_r <= dcl_s2_r;
      fsc_s1_r <= link.fsc;
      fsc_s2_r <= fsc_s1_r;
      dd_s1_r <= link.dd;
      dd_s2_r <= dd_s1_r;
      lvl_s1_r <= line_signal_present;
      lvl_s2_r <= lvl_s1_r;
    end
  end

  // The level detector stays live whatever loop is closed.
  assign level_detect = lvl_s2_r; // see [R10]

  // ****************************************
  // Receive buffer toward the backplane
  // ****************************************
  logic fifo_valid, fifo_pop;
  logic [CHAN_BITS-1:0] fifo_data;

  stg_fifo #(.WIDTH(CHAN_BITS), .DEPTH(FIFO_DEPTH)) stg_fifo_i (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .in_valid(line_rx_valid),
    .in_ready(line_rx_ready),
    .in_data(line_rx_chan),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ****************************************
  // Frame engine
  // ****************************************
  logic rise, fall, boundary, sg_on, has_d, echo_ok, pass_base;
  logic [4:0] idx_r, idx_nxt;
  logic [FRAME_BITS-1:0] dn_r, dn_nxt, up_r, up_nxt;
  logic du_r, du_nxt, fwd_up_r, fwd_up_nxt, fwd_dn_r, fwd_dn_nxt;
  logic e_pass_r, e_pass_nxt, tx_valid_nxt;
  logic [3:0] echo_r, echo_nxt, prio;
  logic [7:0] dly_r, dly_nxt;
  stg_chan_t hold_r, hold_nxt, upw, tx_chan_nxt;
  stg_tx_state_t st_r, st_nxt;

  always_comb begin
    rise = dcl_s2_r & ~dcl_d_r;
    fall = ~dcl_s2_r & dcl_d_r;
    idx_nxt = idx_r;
    dn_nxt = dn_r;
    up_nxt = up_r;
    du_nxt = du_r;
    fwd_up_nxt = fwd_up_r;
    fwd_dn_nxt = fwd_dn_r;
    e_pass_nxt = e_pass_r;
    hold_nxt = hold_r;
    st_nxt = st_r;
    dly_nxt = dly_r;
    tx_valid_nxt = 1'b0;
    tx_chan_nxt = line_tx_chan;
    fifo_pop = 1'b0;
    upw = stg_chan_t'(CHAN_ONES);
    boundary = 1'b0;
    pass_base = activated_state | (sm_disable & (transmit_info_select == TX_INFO_PASS));
    prio = activate_request_class10 ? PRIO_CLASS10 : PRIO_CLASS8;
    echo_ok = (echo_r >= prio); // see [R6]
    sg_on = (mode == MODE_TERMINAL) & d_channel_access_mode[0]; // see [R5]
    echo_nxt = echo_r;
    if (line_rx_valid & line_rx_ready) begin
      echo_nxt = !line_rx_chan.e ? ECHO_RST : (echo_r == 4'hf ? echo_r : echo_r + 4'h1);
    end
    if (rise) begin
      idx_nxt = fsc_s2_r ? FIRST_BIT : idx_r + 5'h1;
      dn_nxt[idx_nxt] = dd_s2_r;
      boundary = (idx_nxt == LAST_BIT);
    end
    if (boundary) begin
      fwd_up_nxt = pass_base; // see [R12]
      e_pass_nxt = (mode == MODE_TERMINAL) | (mode == MODE_LINE_TERMINAL_TRUNK);
      fwd_dn_nxt = (activated_state & (activate_request_class8 | activate_request_class10
                   | activate_request_loop)) // see [R3]
                   | (sm_disable & !transmit_data_block); // see [R4]
      // D bits are sent as received; a withheld D slot stays all ones.
      hold_nxt = fwd_dn_nxt ? stg_chan_t'(dn_nxt[CHAN_BITS-1:0])
                 : stg_chan_t'(CHAN_ONES); // see [R9]
      dly_nxt = 8'(TX_BASE_CYC)
                - (phase_delay_shift ? 8'(PHASE_SHIFT_CYC) : DELAY_RST); // see [R11]
      st_nxt = sg_on ? TX_STOPGO : TX_DELAY; // see [R5]
    end else begin
      unique case (st_r)
        TX_IDLE: begin
          st_nxt = TX_IDLE;
        end
        TX_DELAY: begin
          dly_nxt = dly_r - 8'h1;
          if (dly_r <= 8'h1) begin
            tx_valid_nxt = 1'b1;
            tx_chan_nxt = hold_r;
            st_nxt = TX_IDLE;
          end
        end
        TX_STOPGO: begin
          has_d = (hold_r.d != 2'h3);
          if (!has_d | echo_ok) begin
            tx_valid_nxt = 1'b1;
            tx_chan_nxt = hold_r; // see [R6]
            st_nxt = TX_IDLE;
          end
        end
        default: begin
          st_nxt = TX_IDLE;
        end
      endcase
    end
    has_d = (hold_r.d != 2'h3);
    if (fall) begin
      if (idx_r == LAST_BIT) begin
        // Words are taken as they come; line and backplane frames float.
        fifo_pop = fifo_valid; // see [R7]
        if (fwd_up_r & fifo_valid) begin
          upw = stg_chan_t'(fifo_data); // see [R1]
          if (!e_pass_r) begin
            upw.e = 1'b1; // see [R8]
          end
        end
        up_nxt = {PAD_ONES, upw}; // see [R2]
        du_nxt = up_nxt[0];
      end else begin
        du_nxt = up_r[idx_r + 5'h1];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_r <= LAST_BIT;
      dn_r <= '1;
      up_r <= '1;
      du_r <= 1'b1;
      fwd_up_r <= 1'b0;
      fwd_dn_r <= 1'b0;
      e_pass_r <= 1'b0;
      echo_r <= ECHO_RST;
      dly_r <= DELAY_RST;
      hold_r <= stg_chan_t'(CHAN_ONES);
      st_r <= TX_IDLE;
      line_tx_valid <= 1'b0;
      line_tx_chan <= stg_chan_t'(CHAN_ONES);
    end else begin
      idx_r <= idx_nxt;
      dn_r <= dn_nxt;
      up_r <= up_nxt;
      du_r <= du_nxt;
      fwd_up_r <= fwd_up_nxt;
      fwd_dn_r <= fwd_dn_nxt;
      e_pass_r <= e_pass_nxt;
      echo_r <= echo_nxt;
      dly_r <= dly_nxt;
      hold_r <= hold_nxt;
      st_r <= st_nxt;
      line_tx_valid <= tx_valid_nxt;
      line_tx_chan <= tx_chan_nxt;
    end
  end

  assign link.du = du_r;

endmodule : stg_device

// file: logic/stg_controller.sv
`timescale 1ns/100ps

// ****************************************
// Backplane controller end of the link
// ****************************************
module stg_controller (
  input wire logic ref_clk,
  input wire logic arst_n,
  stg_link_if.ctl link,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire stg_pkg::stg_chan_t tx_chan,
  input wire logic d_access_allow,
  output logic rx_valid,
  output stg_pkg::stg_chan_t rx_chan
);
  import stg_pkg::*;

  logic du_s1_r, du_s2_r;
  logic [3:0] div_r, div_nxt;
  logic dcl_r, dcl_nxt, fsc_r, fsc_nxt, dd_r, dd_nxt, rx_valid_nxt, tog;
  logic [4:0] idx_r, idx_nxt;
  logic [FRAME_BITS-1:0] txf_r, txf_nxt, rxf_r, rxf_nxt;
  stg_chan_t w, rx_chan_nxt;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      du_s1_r <= 1'b1;
      du_s2_r <= 1'b1;
    end else begin
      du_s1_r <= link.du;
      du_s2_r <= du_s1_r;
    end
  end

  // ****************************************
  // Clock divider and frame engine
  // ****************************************
  always_comb begin
    tog = (div_r == 4'(DCL_HALF_CYC - 1));
    div_nxt = tog ? DIV_RST : div_r + 4'h1;
    dcl_nxt = tog ? ~dcl_r : dcl_r;
    idx_nxt = idx_r;
    txf_nxt = txf_r;
    rxf_nxt = rxf_r;
    fsc_nxt = fsc_r;
    dd_nxt = dd_r;
    tx_ready = 1'b0;
    rx_valid_nxt = 1'b0;
    rx_chan_nxt = rx_chan;
    w = stg_chan_t'(CHAN_ONES);
    if (tog & !dcl_r) begin
      rxf_nxt[idx_r] = du_s2_r;
      if (idx_r == LAST_BIT) begin
        rx_valid_nxt = 1'b1;
        rx_chan_nxt = stg_chan_t'(rxf_nxt[CHAN_BITS-1:0]);
      end
    end
    if (tog & dcl_r) begin
      idx_nxt = idx_r + 5'h1;
      if (idx_nxt == FIRST_BIT) begin
        tx_ready = 1'b1;
        if (tx_valid) begin
          w = tx_chan;
        end
        if (!d_access_allow) begin
          w.d = 2'h3; // see [R9]
        end
        txf_nxt = {PAD_ONES, w};
      end
      fsc_nxt = (idx_nxt == FIRST_BIT);
      dd_nxt = txf_nxt[idx_nxt];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_r <= DIV_RST;
      dcl_r <= 1'b1;
      idx_r <= LAST_BIT;
      txf_r <= '1;
      rxf_r <= '1;
      fsc_r <= 1'b0;
      dd_r <= 1'b1;
      rx_valid <= 1'b0;
      rx_chan <= stg_chan_t'(CHAN_ONES);
    end else begin
      div_r <= div_nxt;
      dcl_r <= dcl_nxt;
      idx_r <= idx_nxt;
      txf_r <= txf_nxt;
      rxf_r <= rxf_nxt;
      fsc_r <= fsc_nxt;
      dd_r <= dd_nxt;
      rx_valid <= rx_valid_nxt;
      rx_chan <= rx_chan_nxt;
    end
  end

  assign link.dcl = dcl_r;
  assign link.fsc = fsc_r;
  assign link.dd = dd_r;

endmodule : stg_controller

// file: test/stg_link_chk.sv
`timescale 1ns/100ps
// ****************************************
// Wire checks on the backplane link
// ****************************************
module stg_link_chk (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic dcl,
  input wire logic fsc,
  input wire logic dd,
  input wire logic du
);
  import stg_pkg::*;
  logic dcl_q_r, fsc_q_r, dseen_r, fseen_r, dcl_rise;
  logic [10:0] dcnt_r, dcnt_nxt, fcnt_r, fcnt_nxt;
  logic [5:0] bidx_r, bidx_nxt;
  assign dcl_rise = dcl && !dcl_q_r;
  always_comb begin
    dcnt_nxt = (dcl != dcl_q_r) ? 11'h000 : dcnt_r + 11'h001;
    fcnt_nxt = (fsc && !fsc_q_r) ? 11'h000 : fcnt_r + 11'h001;
    bidx_nxt = !dcl_rise ? bidx_r : (fsc ? 6'h01 : bidx_r + 6'h01);
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dcl_q_r <= 1'b1;
      fsc_q_r <= 1'b0;
      dseen_r <= 1'b0;
      fseen_r <= 1'b0;
      dcnt_r <= 11'h000;
      fcnt_r <= 11'h000;
      bidx_r <= 6'h00;
    end else begin
      dcl_q_r <= dcl;
      fsc_q_r <= fsc;
      dseen_r <= dseen_r | (dcl != dcl_q_r);
      fseen_r <= fseen_r | (fsc && !fsc_q_r);
      dcnt_r <= dcnt_nxt;
      fcnt_r <= fcnt_nxt;
      bidx_r <= bidx_nxt;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_dcl_half; (dcl != dcl_q_r) && dseen_r |-> dcnt_r == DCL_HALF_CYC - 1; endproperty
  a_dcl_half: assert property (p_dcl_half) else $error("dcl half period wrong");
  property p_fsc_period; fsc && !fsc_q_r && fseen_r |-> fcnt_r == 11'(FRAME_CYC - 1); endproperty
  a_fsc_period: assert property (p_fsc_period) else $error("frame length wrong");
  property p_fsc_width; $rose(fsc) |-> fsc [*8]; endproperty
  a_fsc_width: assert property (p_fsc_width) else $error("frame sync too short");
  property p_fsc_low; $changed(fsc) |-> !dcl; endproperty
  a_fsc_low: assert property (p_fsc_low) else $error("frame sync moved early");
  property p_dd_low; $changed(dd) |-> !dcl; endproperty
  a_dd_low: assert property (p_dd_low) else $error("downstream bit moved early");
  property p_du_low; $changed(du) |-> !dcl; endproperty
  a_du_low: assert property (p_du_low) else $error("upstream bit moved early");
  property p_du_pad; dcl_rise && !fsc && fseen_r && bidx_r >= 6'h13 |-> du; endproperty
  a_du_pad: assert property (p_du_pad) else $error("upstream pad bit not one");
  property p_dd_pad; dcl_rise && !fsc && fseen_r && bidx_r >= 6'h13 |-> dd; endproperty
  a_dd_pad: assert property (p_dd_pad) else $error("downstream pad bit not one");
endmodule : stg_link_chk

// file: test/st_to_backplane_channel_gate_tb.sv
`timescale 1ns/100ps
module st_to_backplane_channel_gate_tb;
  import stg_pkg::*;
  localparam int FRM = FRAME_CYC;
  localparam stg_chan_t W1 = 19'h3a5c3;
  localparam stg_chan_t W2 = 19'h1c3a5;
  logic ref_clk, arst_n, activated_state, sm_disable, transmit_data_block, phase_delay_shift;
  logic activate_request_class8, activate_request_class10, activate_request_loop;
  logic line_rx_valid, line_rx_ready, line_signal_present, level_detect, line_tx_valid;
  logic tx_valid, tx_ready, d_access_allow, rx_valid;
  logic [2:0] transmit_info_select, d_channel_access_mode;
  stg_mode_t mode;
  stg_chan_t line_rx_chan, line_tx_chan, tx_chan, rx_chan;
  int err_count, cmp_count;
  stg_link_if link_a();
  stg_device stg_device_i (.ref_clk, .arst_n, .link(link_a), .mode, .activated_state,
    .sm_disable, .transmit_info_select, .transmit_data_block, .activate_request_class8,
    .activate_request_class10, .activate_request_loop, .d_channel_access_mode,
    .phase_delay_shift, .line_rx_valid, .line_rx_ready, .line_rx_chan,
    .line_signal_present, .level_detect, .line_tx_valid, .line_tx_chan);
  stg_controller stg_controller_i (.ref_clk, .arst_n, .link(link_a), .tx_valid, .tx_ready,
    .tx_chan, .d_access_allow, .rx_valid, .rx_chan);
  stg_link_chk stg_link_chk_i (.ref_clk(ref_clk), .arst_n(arst_n), .dcl(link_a.dcl),
    .fsc(link_a.fsc), .dd(link_a.dd), .du(link_a.du));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task end_of_test;
    $display("TB: errors=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task chk(input stg_chan_t got, input stg_chan_t exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task frm_chk(input bit dn, input stg_chan_t exp);
    int i;
    repeat (3 * FRM) @(negedge ref_clk);
    for (i = 0; i < 2 * FRM && (dn ? line_tx_valid : rx_valid) !== 1'b1; i++) @(negedge ref_clk);
    if (i >= 2 * FRM) begin
      err_count++;
      $display("ERROR t=%0t no word got=%h exp=%h", $time, dn ? line_tx_chan : rx_chan, exp);
    end
    chk(dn ? line_tx_chan : rx_chan, exp);
    @(posedge ref_clk);
  endtask : frm_chk
  task tx_offs(output int n);
    int i;
    for (i = 0; i < 2 * FRM && link_a.fsc !== 1'b0; i++) @(negedge ref_clk);
    for (i = 0; i < 2 * FRM && link_a.fsc !== 1'b1; i++) @(negedge ref_clk);
    for (n = 0; n < FRM && line_tx_valid !== 1'b1; n++) @(negedge ref_clk);
    @(posedge ref_clk);
  endtask : tx_offs
  task t_up;
    @(posedge ref_clk);
    activated_state <= 1'b1;
    frm_chk(0, W1);
    activated_state <= 1'b0;
    frm_chk(0, CHAN_ONES);
    sm_disable <= 1'b1;
    transmit_info_select <= TX_INFO_PASS;
    frm_chk(0, W1);
    transmit_info_select <= 3'h2;
    frm_chk(0, CHAN_ONES);
    sm_disable <= 1'b0;
    activated_state <= 1'b1;
  endtask : t_up
  task t_modes;
    stg_mode_t ml [3] = '{MODE_LINE_TERMINAL_TRUNK, MODE_LINE_TERMINAL_SUBSCRIBER, MODE_NETWORK};
    for (int k = 0; k < 3; k++) begin
      mode <= ml[k];
      frm_chk(0, (k == 0) ? W1 : (W1 | 19'h40000));
    end
  endtask : t_modes
  task t_down;
    for (int k = 0; k < 3; k++) begin
      {activate_request_class8, activate_request_class10, activate_request_loop} <= 3'h4 >> k;
      frm_chk(1, W2);
    end
    {activate_request_class8, activate_request_class10, activate_request_loop} <= 3'h0;
    frm_chk(1, CHAN_ONES);
    activated_state <= 1'b0;
    sm_disable <= 1'b1;
    frm_chk(1, W2);
    transmit_data_block <= 1'b1;
    frm_chk(1, CHAN_ONES);
    sm_disable <= 1'b0;
    activated_state <= 1'b1;
    activate_request_class8 <= 1'b1;
    d_access_allow <= 1'b0;
    frm_chk(1, W2 | 19'h30000);
    d_access_allow <= 1'b1;
  endtask : t_down
  task t_pds;
    int n0, n1;
    tx_offs(n0);
    phase_delay_shift <= 1'b1;
    repeat (2 * FRM) @(negedge ref_clk);
    tx_offs(n1);
    chk(19'(n0 - n1), 19'(PHASE_SHIFT_CYC));
    phase_delay_shift <= 1'b0;
  endtask : t_pds
  task t_sg;
    int cnt;
    mode <= MODE_TERMINAL;
    d_channel_access_mode <= 3'h1;
    repeat (3 * FRM) @(negedge ref_clk);
    cnt = 0;
    repeat (2 * FRM) @(negedge ref_clk) cnt += int'(line_tx_valid === 1'b1);
    chk(19'(cnt), 19'h0);
    @(posedge ref_clk);
    line_rx_chan <= W1 | 19'h40000;
    repeat (8 * FRM) @(negedge ref_clk);
    frm_chk(1, W2);
  endtask : t_sg
  task t_lvl;
    @(posedge ref_clk);
    line_signal_present <= 1'b1;
    repeat (6) @(negedge ref_clk);
    chk({18'h0, level_detect}, 19'h1);
    @(posedge ref_clk);
    line_signal_present <= 1'b0;
    repeat (6) @(negedge ref_clk);
    chk({18'h0, level_detect}, 19'h0);
  endtask : t_lvl
  task t_rdy;
    int nrx, ntx;
    nrx = 0;
    ntx = 0;
    repeat (2 * FRM) @(negedge ref_clk) begin
      nrx += int'(line_rx_ready === 1'b1);
      ntx += int'(tx_ready === 1'b1);
    end
    chk(19'(nrx), 19'h2);
    chk(19'(ntx), 19'h2);
  endtask : t_rdy
  initial begin
    {arst_n, activated_state, sm_disable, transmit_data_block, phase_delay_shift} = 5'h0;
    {activate_request_class8, activate_request_class10, activate_request_loop} = 3'h0;
    {line_signal_present, tx_valid} = 2'h1;
    line_rx_valid = 1'b1;
    d_access_allow = 1'b1;
    transmit_info_select = 3'h0;
    d_channel_access_mode = 3'h0;
    mode = MODE_TERMINAL;
    line_rx_chan = W1;
    tx_chan = W2;
    err_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_up();
    t_modes();
    t_down();
    t_pds();
    t_sg();
    t_lvl();
    t_rdy();
    end_of_test();
  end
  initial begin
    repeat (99000) @(posedge ref_clk);
    err_count++;
    $display("ERROR t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
    end_of_test();
  end
endmodule : st_to_backplane_channel_gate_tb
